/* include/apal_params.svh */
// Constants for the attribute and palette access block
`ifndef APAL_PARAMS_SVH
`define APAL_PARAMS_SVH
`define APAL_PORT_ATTR_WR 16'h03C0
`define APAL_PORT_ATTR_RD 16'h03C1
`define APAL_PORT_MASK 16'h03C6
`define APAL_PORT_RDIDX 16'h03C7
`define APAL_PORT_WRIDX 16'h03C8
`define APAL_PORT_DATA 16'h03C9
`define APAL_PORT_STAT_MONO 16'h03BA
`define APAL_PORT_STAT_COLOR 16'h03DA
`define APAL_IDX_MODE 5'h10
`define APAL_IDX_BORDER 5'h11
`define APAL_IDX_PLANE 5'h12
`define APAL_IDX_PAN 5'h13
`define APAL_IDX_PAD 5'h14
`define APAL_MODE_GFX 0
`define APAL_MODE_LINEGFX 2
`define APAL_MODE_BLINK 3
`define APAL_MODE_SPLITPAN 5
`define APAL_MODE_ASM256 6
`define APAL_MODE_SEL54 7
`define APAL_IDX_VIDEO_EN 5
`define APAL_LINEGFX_LO 8'hC0
`define APAL_LINEGFX_HI 8'hDF
`define APAL_PAN_NONE_9DOT 4'h8
`define APAL_STATE_WRITE 2'h0
`define APAL_STATE_READ 2'h3
`define APAL_FIFO_DEPTH 16
`define APAL_FIFO_AW 4
`endif

/* include/apal_pkg.sv */
// Types shared by the attribute and palette access block
package apal_pkg;
    typedef enum logic [1:0] {
        APAL_RED = 2'h0,
        APAL_GRN = 2'h1,
        APAL_BLU = 2'h2
    } apal_rgb_e;
    typedef struct packed {
        logic [3:0] plane;
        logic [7:0] char_code;
        logic ninth_dot;
        logic blink_attr;
        logic bg_bright;
        logic active;
        logic border;
        logic lower_screen;
    } apal_pix_s;
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } apal_io_s;
endpackage

/* rtl/apal_fifo.sv */
// Parameterised valid/ready FIFO for the pixel path
`timescale 1ns/1ps
module apal_fifo #(
    parameter int WIDTH = 17,
    parameter int DEPTH = 16,
    parameter int AW = 4
) (
    input wire logic core_clk_in,
    input wire logic nrst_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [AW:0] cnt_q;
    logic push;
    logic pop;
    assign in_ready_out = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid_out = (cnt_q != '0);
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;
    assign out_data_out = mem_q[rp_q];
    always_ff @(posedge core_clk_in)
    begin
        if (push)
        begin
            mem_q[wp_q] <= in_data_in;
        end
    end
    always_ff @(posedge core_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end
        else
        begin
            if (push)
            begin
                wp_q <= wp_q + 1'b1;
            end
            if (pop)
            begin
                rp_q <= rp_q + 1'b1;
            end
            if (push && !pop)
            begin
                cnt_q <= cnt_q + 1'b1;
            end
            else if (pop && !push)
            begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule // apal_fifo

/* rtl/apal_top.sv */
// Attribute colour stage and palette access logic
`timescale 1ns/1ps
`include "apal_params.svh"
// Overview of operation
// RULE_01 - Index low five bits pick attribute register
// RULE_02 - Video enable bit locks colour map access; code locks writes only, 3C1 reads still see it
// RULE_03 - Colour map holds six bits, top zero
// RULE_04 - Attribute data read 3C1, written 3C0/3C1
// RULE_05 - Line graphics codes copy eighth dot ninth
// RULE_06 - Blink on vsync, else background intensity
// RULE_07 - Split pan mode pans top screen only
// RULE_08 - 256 colour mode pairs nibbles, half rate
// RULE_09 - Pad bits replace video bits five four
// RULE_10 - Border colour shown outside display area
// RULE_11 - Plane enable zeroes disabled plane bits
// RULE_12 - Status select routes colour bit pairs
// RULE_13 - Pan shifts left, nine dot offset
// RULE_14 - 256 colour pan uses value halved
// RULE_15 - Pad low bits unused in 256 colour
// RULE_16 - Pad bits drive video seven six
// RULE_17 - Pixel mask ANDs palette address
// RULE_18 - Palette state shows last index port
// RULE_19 - 256 entries, 18 bits, red green blue
// RULE_20 - Index written 3C7/3C8, read 3C8 only
// RULE_21 - Index write loads index and save
// RULE_22 - Read mode index write pre-increments index
// RULE_23 - Third data access increments both
// RULE_24 - Index write restarts colour sequence
// RULE_25 - Status read resets toggle, 3C0 flips
// RULE_26 - Reads ignore the toggle
// RULE_27 - Reset sets red and index toggle
module apal_top (
    input wire logic core_clk_in,
    input wire logic nrst_in,
    input wire apal_pkg::apal_io_s io_in,
    output logic [7:0] io_rdata_out,
    input wire logic pix_valid_in,
    output logic pix_ready_out,
    input wire apal_pkg::apal_pix_s pix_in,
    input wire logic vsync_in,
    output logic [17:0] rgb_out,
    output logic rgb_valid_out,
    input wire logic rgb_ready_in,
    output logic [1:0] status_bits_out
);
    // ---------------------------------------------------------------
    // Attribute registers
    // ---------------------------------------------------------------
    logic [5:0] cmap_q [16];
    logic [7:0] mode_q;
    logic [7:0] border_q;
    logic [5:0] plane_q;
    logic [3:0] pan_q;
    logic [3:0] pad_q;
    logic [5:0] aidx_q;
    logic flip_q;
    logic [7:0] pmask_q;
    logic [7:0] pidx_q;
    logic [7:0] psave_q;
    logic pstate_q;
    apal_pkg::apal_rgb_e seq_q;
    logic [5:0] red_q;
    logic [5:0] grn_q;
    logic [17:0] pal_q [256];
    logic aw;
    logic stat_rd;
    logic dat_wr;
    logic dat_rd;
    logic cmap_open;
    assign stat_rd = io_in.rd && (io_in.addr == `APAL_PORT_STAT_MONO
        || io_in.addr == `APAL_PORT_STAT_COLOR);
    // Data write at 3C0 when toggle points to data, or any 3C1 write
    assign aw = io_in.wr && ((io_in.addr == `APAL_PORT_ATTR_WR && flip_q)
        || io_in.addr == `APAL_PORT_ATTR_RD); // RULE_04
    assign cmap_open = !aidx_q[`APAL_IDX_VIDEO_EN]; // RULE_02
    assign dat_wr = io_in.wr && io_in.addr == `APAL_PORT_DATA;
    assign dat_rd = io_in.rd && io_in.addr == `APAL_PORT_DATA;
    always_ff @(posedge core_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            flip_q <= 1'b0; // RULE_27
        end
        else if (stat_rd)
        begin
            flip_q <= 1'b0; // RULE_25
        end
        else if (io_in.wr && io_in.addr == `APAL_PORT_ATTR_WR)
        begin
            flip_q <= !flip_q; // RULE_25
        end
    end
    always_ff @(posedge core_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            aidx_q <= 6'h00;
        end
        else if (io_in.wr && io_in.addr == `APAL_PORT_ATTR_WR && !flip_q)
        begin
            aidx_q <= io_in.wdata[5:0];
        end
    end
    always_ff @(posedge core_clk_in)
    begin
        if (aw && !aidx_q[4] && cmap_open) // RULE_01 RULE_02
        begin
            cmap_q[aidx_q[3:0]] <= io_in.wdata[5:0]; // RULE_03
        end
    end
    always_ff @(posedge core_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            mode_q <= 8'h00;
            border_q <= 8'h00;
            plane_q <= 6'h0F;
            pan_q <= 4'h0;
            pad_q <= 4'h0;
        end
        else if (aw)
        begin
            case (aidx_q[4:0]) // RULE_01
                `APAL_IDX_MODE: mode_q <= io_in.wdata & 8'hEF;
                `APAL_IDX_BORDER: border_q <= io_in.wdata;
                `APAL_IDX_PLANE: plane_q <= io_in.wdata[5:0];
                `APAL_IDX_PAN: pan_q <= io_in.wdata[3:0];
                `APAL_IDX_PAD: pad_q <= io_in.wdata[3:0];
                default: ;
            endcase
        end
    end
    // ---------------------------------------------------------------
    // Palette access
    // ---------------------------------------------------------------
    always_ff @(posedge core_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            pmask_q <= 8'hFF;
            pidx_q <= 8'h00;
            psave_q <= 8'h00;
            pstate_q <= 1'b0;
            seq_q <= apal_pkg::APAL_RED; // RULE_27
            red_q <= 6'h00;
            grn_q <= 6'h00;
        end
        else if (io_in.wr && io_in.addr == `APAL_PORT_MASK)
        begin
            pmask_q <= io_in.wdata;
        end
        else if (io_in.wr && io_in.addr == `APAL_PORT_RDIDX)
        begin
            psave_q <= io_in.wdata; // RULE_21
            pidx_q <= io_in.wdata + 8'h01; // RULE_22
            pstate_q <= 1'b1; // RULE_18
            seq_q <= apal_pkg::APAL_RED; // RULE_24
        end
        else if (io_in.wr && io_in.addr == `APAL_PORT_WRIDX)
        begin
            psave_q <= io_in.wdata; // RULE_21
            pidx_q <= io_in.wdata; // RULE_22
            pstate_q <= 1'b0; // RULE_18
            seq_q <= apal_pkg::APAL_RED; // RULE_24
        end
        else if (dat_wr || dat_rd)
        begin
            case (seq_q)
                apal_pkg::APAL_RED:
                begin
                    if (dat_wr)
                    begin
                        red_q <= io_in.wdata[5:0];
                    end
                    seq_q <= apal_pkg::APAL_GRN;
                end
                apal_pkg::APAL_GRN:
                begin
                    if (dat_wr)
                    begin
                        grn_q <= io_in.wdata[5:0];
                    end
                    seq_q <= apal_pkg::APAL_BLU;
                end
                default:
                begin
                    psave_q <= psave_q + 8'h01; // RULE_23
                    pidx_q <= pidx_q + 8'h01; // RULE_23
                    seq_q <= apal_pkg::APAL_RED;
                end
            endcase
        end
    end
    // Entry committed on blue write; earlier bytes staged
    always_ff @(posedge core_clk_in)
    begin
        if (dat_wr && seq_q == apal_pkg::APAL_BLU)
        begin
            pal_q[psave_q] <= {red_q, grn_q, io_in.wdata[5:0]}; // RULE_19
        end
    end
    // ---------------------------------------------------------------
    // Read mux
    // ---------------------------------------------------------------
    logic [7:0] ard;
    logic [17:0] pent;
    always_comb
    begin
        pent = pal_q[psave_q];
        case (aidx_q[4:0])
            `APAL_IDX_MODE: ard = mode_q;
            `APAL_IDX_BORDER: ard = border_q;
            `APAL_IDX_PLANE: ard = {2'b00, plane_q};
            `APAL_IDX_PAN: ard = {4'h0, pan_q};
            `APAL_IDX_PAD: ard = {4'h0, pad_q};
            default: ard = aidx_q[4] ? 8'h00
                : {2'b00, cmap_q[aidx_q[3:0]]}; // RULE_03
        endcase
    end
    always_ff @(posedge core_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            io_rdata_out <= 8'h00;
        end
        else if (io_in.rd)
        begin
            case (io_in.addr) // RULE_26
                `APAL_PORT_ATTR_WR: io_rdata_out <= {2'b00, aidx_q};
                `APAL_PORT_ATTR_RD: io_rdata_out <= ard;
                `APAL_PORT_MASK: io_rdata_out <= pmask_q;
                `APAL_PORT_RDIDX: io_rdata_out <= {6'h00,
                    pstate_q ? `APAL_STATE_READ : `APAL_STATE_WRITE};
                `APAL_PORT_WRIDX: io_rdata_out <= pidx_q; // RULE_20
                `APAL_PORT_DATA:
                begin
                    case (seq_q) // RULE_19
                        apal_pkg::APAL_RED: io_rdata_out <= {2'b00, pent[17:12]};
                        apal_pkg::APAL_GRN: io_rdata_out <= {2'b00, pent[11:6]};
                        default: io_rdata_out <= {2'b00, pent[5:0]};
                    endcase
                end
                default: io_rdata_out <= 8'h00;
            endcase
        end
    end
    // ---------------------------------------------------------------
    // Pixel path: FIFO, blink, pan, attribute map
    // ---------------------------------------------------------------
    localparam int PW = $bits(apal_pkg::apal_pix_s);
    apal_pkg::apal_pix_s fp;
    logic f_valid;
    logic f_ready;
    logic [PW-1:0] f_data;
    apal_fifo #(.WIDTH(PW), .DEPTH(`APAL_FIFO_DEPTH),
        .AW(`APAL_FIFO_AW)) u_fifo (
        .core_clk_in(core_clk_in),
        .nrst_in(nrst_in),
        .in_valid_in(pix_valid_in),
        .in_ready_out(pix_ready_out),
        .in_data_in(pix_in),
        .out_valid_out(f_valid),
        .out_ready_in(f_ready),
        .out_data_out(f_data)
    );
    assign fp = f_data;
    logic vs_s1_q;
    logic vs_s2_q;
    logic vs_d_q;
    logic [4:0] blink_q;
    always_ff @(posedge core_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            vs_s1_q <= 1'b0;
            vs_s2_q <= 1'b0;
            vs_d_q <= 1'b0;
            blink_q <= 5'h00;
        end
        else
        begin
            vs_s1_q <= vsync_in;
            vs_s2_q <= vs_s1_q;
            vs_d_q <= vs_s2_q;
            if (vs_s2_q && !vs_d_q)
            begin
                blink_q <= blink_q + 5'h01; // RULE_06
            end
        end
    end
    // Pan delay line: stream dots through history, pick an older tap
    logic [3:0] hist_q [9];
    logic [3:0] shift;
    logic [3:0] pan_eff;
    logic [3:0] dot;
    logic [3:0] pl;
    logic blinkoff;
    logic [5:0] cm;
    logic [7:0] v8;
    logic [3:0] lo_nib_q;
    logic half_q;
    logic [7:0] vout_q;
    logic v_valid_q;
    logic emit;
    always_comb
    begin
        pan_eff = (mode_q[`APAL_MODE_SPLITPAN] && fp.lower_screen)
            ? 4'h0 : pan_q; // RULE_07
        if (mode_q[`APAL_MODE_ASM256])
        begin
            shift = {1'b0, pan_eff[3:1]}; // RULE_14
        end
        else if (!mode_q[`APAL_MODE_GFX])
        begin
            // Text taken as nine-dot cells; codes 8 and up do not shift
            shift = (pan_eff >= `APAL_PAN_NONE_9DOT) ? 4'h0
                : pan_eff + 4'h1; // RULE_13
        end
        else
        begin
            shift = {1'b0, pan_eff[2:0]}; // RULE_13
        end
        dot = (shift == 4'h0) ? fp.plane : hist_q[shift - 4'h1];
        if (fp.ninth_dot && !(mode_q[`APAL_MODE_LINEGFX]
            && fp.char_code >= `APAL_LINEGFX_LO
            && fp.char_code <= `APAL_LINEGFX_HI))
        begin
            dot = 4'h0; // RULE_05
        end
        blinkoff = mode_q[`APAL_MODE_BLINK] && fp.blink_attr
            && blink_q[4]; // RULE_06
        pl = (blinkoff ? 4'h0 : dot) & plane_q[3:0]; // RULE_11
        if (!mode_q[`APAL_MODE_BLINK] && fp.bg_bright)
        begin
            pl[3] = 1'b1; // RULE_06
        end
        cm = cmap_q[pl];
        v8 = {pad_q[3:2], mode_q[`APAL_MODE_SEL54] ? pad_q[1:0]
            : cm[5:4], cm[3:0]}; // RULE_09 RULE_15 RULE_16
        if (!fp.active && fp.border)
        begin
            v8 = border_q; // RULE_10
        end
    end
    assign emit = f_valid && (!v_valid_q || rgb_ready_in);
    assign f_ready = emit;
    always_ff @(posedge core_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            for (int i = 0; i < 9; i++)
            begin
                hist_q[i] <= 4'h0;
            end
            lo_nib_q <= 4'h0;
            half_q <= 1'b0;
            vout_q <= 8'h00;
            v_valid_q <= 1'b0;
        end
        else
        begin
            if (v_valid_q && rgb_ready_in)
            begin
                v_valid_q <= 1'b0;
            end
            if (emit)
            begin
                hist_q[0] <= fp.plane;
                for (int i = 1; i < 9; i++)
                begin
                    hist_q[i] <= hist_q[i-1];
                end
                if (mode_q[`APAL_MODE_ASM256] && fp.active)
                begin
                    half_q <= !half_q;
                    if (!half_q)
                    begin
                        lo_nib_q <= v8[3:0];
                    end
                    else
                    begin
                        vout_q <= {lo_nib_q, v8[3:0]}; // RULE_08 RULE_15
                        v_valid_q <= 1'b1;
                    end
                end
                else
                begin
                    half_q <= 1'b0;
                    vout_q <= v8; // RULE_08
                    v_valid_q <= 1'b1;
                end
            end
        end
    end
    // ---------------------------------------------------------------
    // Palette lookup and status bits
    // ---------------------------------------------------------------
    assign rgb_out = pal_q[vout_q & pmask_q]; // RULE_17
    assign rgb_valid_out = v_valid_q;
    always_comb
    begin
        case (plane_q[5:4]) // RULE_12
            2'b00: status_bits_out = {vout_q[2], vout_q[0]};
            2'b01: status_bits_out = {vout_q[5], vout_q[4]};
            2'b10: status_bits_out = {vout_q[3], vout_q[1]};
            default: status_bits_out = {vout_q[7], vout_q[6]};
        endcase
    end
    AST_TOGGLE_CLR: assert property (@(posedge core_clk_in)
        disable iff (!nrst_in) stat_rd |=> !flip_q) // RULE_25
        else $error("toggle not cleared");
    AST_RDIDX_INC: assert property (@(posedge core_clk_in)
        disable iff (!nrst_in)
        io_in.wr && io_in.addr == `APAL_PORT_RDIDX
        |=> pidx_q == psave_q + 8'h01 && pstate_q) // RULE_22
        else $error("read index not incremented");
    AST_WRIDX_EQ: assert property (@(posedge core_clk_in)
        disable iff (!nrst_in)
        io_in.wr && io_in.addr == `APAL_PORT_WRIDX
        |=> pidx_q == psave_q && !pstate_q) // RULE_21
        else $error("write index mismatch");
    AST_SEQ_RST: assert property (@(posedge core_clk_in)
        disable iff (!nrst_in)
        io_in.wr && (io_in.addr == `APAL_PORT_WRIDX
        || io_in.addr == `APAL_PORT_RDIDX)
        |=> seq_q == apal_pkg::APAL_RED) // RULE_24
        else $error("sequence not restarted");
    AST_THIRD_INC: assert property (@(posedge core_clk_in)
        disable iff (!nrst_in)
        (dat_wr || dat_rd) && seq_q == apal_pkg::APAL_BLU
        |=> psave_q == $past(psave_q) + 8'h01) // RULE_23
        else $error("save not incremented");
    AST_CMAP_LOCK: assert property (@(posedge core_clk_in)
        disable iff (!nrst_in)
        aw && !aidx_q[4] && !cmap_open
        |=> cmap_q[$past(aidx_q[3:0])]
        == $past(cmap_q[aidx_q[3:0]])) // RULE_02
        else $error("colour map written while locked");
    AST_STATE_RD: assert property (@(posedge core_clk_in)
        disable iff (!nrst_in)
        io_in.rd && io_in.addr == `APAL_PORT_RDIDX
        |=> io_rdata_out[7:2] == 6'h00) // RULE_18
        else $error("state upper bits set");
    AST_FLIP: assert property (@(posedge core_clk_in)
        disable iff (!nrst_in)
        io_in.wr && io_in.addr == `APAL_PORT_ATTR_WR && !stat_rd
        |=> flip_q != $past(flip_q)) // RULE_25
        else $error("toggle did not flip");
endmodule // apal_top

/* sim/apal_video_sink.sv */
// Video sink partner that takes palette output under back-pressure
`timescale 1ns/1ps
module apal_video_sink (
    input wire logic core_clk_in,
    input wire logic nrst_in,
    input wire logic [17:0] rgb_in,
    input wire logic rgb_valid_in,
    output logic rgb_ready_out,
    output logic [17:0] last_rgb_out
);
    logic [1:0] phase_q;
    // Stall one cycle in three so the pixel FIFO backs up without filling
    always_ff @(posedge core_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            phase_q <= 2'h0;
            last_rgb_out <= 18'h00000;
        end
        else
        begin
            phase_q <= (phase_q == 2'h2) ? 2'h0 : phase_q + 2'h1;
            if (rgb_valid_in && rgb_ready_out)
            begin
                last_rgb_out <= rgb_in;
            end
        end
    end
    assign rgb_ready_out = (phase_q != 2'h2);
endmodule // apal_video_sink

/* sim/testbench.sv */
// Self-checking bench for the attribute and palette access block
`timescale 1ns/1ps
module testbench;
    logic core_clk_in = 1'b0;
    logic nrst_in = 1'b0;
    apal_pkg::apal_io_s io = '0;
    apal_pkg::apal_pix_s pix = '0;
    logic pix_valid = 1'b0;
    logic vsync = 1'b0;
    logic [7:0] rdata;
    logic pix_ready;
    logic [17:0] rgb;
    logic rgb_valid;
    logic rgb_ready;
    logic [17:0] last_rgb;
    logic [1:0] status;
    logic [7:0] tmp;
    int bad_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    always #2 core_clk_in = ~core_clk_in;
    apal_top i_dut (.core_clk_in(core_clk_in), .nrst_in(nrst_in),
        .io_in(io), .io_rdata_out(rdata), .pix_valid_in(pix_valid),
        .pix_ready_out(pix_ready), .pix_in(pix), .vsync_in(vsync),
        .rgb_out(rgb), .rgb_valid_out(rgb_valid),
        .rgb_ready_in(rgb_ready), .status_bits_out(status));
    apal_video_sink i_sink (.core_clk_in(core_clk_in), .nrst_in(nrst_in),
        .rgb_in(rgb), .rgb_valid_in(rgb_valid), .rgb_ready_out(rgb_ready),
        .last_rgb_out(last_rgb));
    // --------------------------------------------------------------
    // Access tasks
    // --------------------------------------------------------------
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic check(input string name, input logic [17:0] seen,
        input logic [17:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // One idle edge before each strobe so no signal is set twice at once
    task automatic io_wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge core_clk_in);
        #1 io = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk_in);
        #1 io = '0;
    endtask
    task automatic io_rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge core_clk_in);
        #1 io = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk_in);
        #1 io = '0;
        d = rdata;
    endtask
    task automatic rd_chk(input string n, input logic [15:0] a,
        input logic [7:0] e);
        io_rd(a, tmp);
        check(n, {10'h000, tmp}, {10'h000, e});
    endtask
    // Status read first so the data write always follows the index
    task automatic attr(input logic [7:0] idx, input logic [7:0] d);
        io_rd(`APAL_PORT_STAT_COLOR, tmp);
        io_wr(`APAL_PORT_ATTR_WR, idx);
        io_wr(`APAL_PORT_ATTR_WR, d);
    endtask
    // Same pixel repeated so pan delay does not change the result
    task automatic pix_run(input logic [3:0] pl, input logic act,
        input logic brd, input logic [17:0] e);
        pix.plane = pl;
        pix.active = act;
        pix.border = brd;
        pix_valid = 1'b1;
        for (int i = 0; i < 24; i++)
        begin
            while (pix_ready !== 1'b1)
            begin
                @(posedge core_clk_in);
                #1;
            end
            @(posedge core_clk_in);
            #1;
        end
        pix_valid = 1'b0;
        repeat (60) @(posedge core_clk_in);
        #1 check("rgb", last_rgb, e);
    endtask
    always @(posedge core_clk_in)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            bad_count++;
            tally_and_finish();
        end
    end
    // --------------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------------
    initial
    begin
        repeat (2) @(posedge core_clk_in);
        #1 nrst_in = 1'b1;
        rd_chk("mask", `APAL_PORT_MASK, 8'hFF);
        attr(8'h01, 8'hFF);
        rd_chk("cmap", `APAL_PORT_ATTR_RD, 8'h3F);
        rd_chk("index", `APAL_PORT_ATTR_WR, 8'h01);
        io_wr(`APAL_PORT_ATTR_RD, 8'h15);
        rd_chk("cmap", `APAL_PORT_ATTR_RD, 8'h15);
        attr(8'h21, 8'h2A);
        attr(8'h21, 8'h00);
        io_rd(`APAL_PORT_STAT_COLOR, tmp);
        io_wr(`APAL_PORT_ATTR_WR, 8'h01);
        rd_chk("cmap", `APAL_PORT_ATTR_RD, 8'h15);
        io_wr(`APAL_PORT_WRIDX, 8'h10);
        for (int i = 1; i <= 6; i++)
            io_wr(`APAL_PORT_DATA, 8'(i));
        rd_chk("index", `APAL_PORT_WRIDX, 8'h12);
        rd_chk("state", `APAL_PORT_RDIDX, 8'h00);
        io_wr(`APAL_PORT_RDIDX, 8'h10);
        rd_chk("index", `APAL_PORT_WRIDX, 8'h11);
        rd_chk("state", `APAL_PORT_RDIDX, 8'h03);
        for (int i = 1; i <= 3; i++)
            rd_chk("data", `APAL_PORT_DATA, 8'(i));
        rd_chk("index", `APAL_PORT_WRIDX, 8'h12);
        io_wr(`APAL_PORT_RDIDX, 8'h11);
        rd_chk("data", `APAL_PORT_DATA, 8'h04);
        io_wr(`APAL_PORT_WRIDX, 8'h11);
        rd_chk("data", `APAL_PORT_DATA, 8'h04);
        attr(8'h05, 8'h10);
        attr(8'h01, 8'h11);
        attr(8'h30, 8'h01);
        attr(8'h33, 8'h00);
        attr(8'h34, 8'h00);
        attr(8'h31, 8'h10);
        attr(8'h32, 8'h1F);
        pix_run(4'h5, 1'b1, 1'b0, 18'h01083);
        check("status", {16'h0000, status}, 18'h00001);
        attr(8'h32, 8'h0B);
        pix_run(4'h5, 1'b1, 1'b0, 18'h04146);
        check("status", {16'h0000, status}, 18'h00001);
        pix_run(4'h5, 1'b0, 1'b1, 18'h01083);
        io_wr(`APAL_PORT_MASK, 8'h10);
        pix_run(4'h5, 1'b1, 1'b0, 18'h01083);
        io_wr(`APAL_PORT_WRIDX, 8'h00);
        for (int i = 7; i <= 12; i++)
            io_wr(`APAL_PORT_DATA, 8'(i));
        io_wr(`APAL_PORT_MASK, 8'h01);
        attr(8'h00, 8'h00);
        attr(8'h09, 8'h20);
        attr(8'h34, 8'h0E);
        attr(8'h30, 8'h81);
        pix_run(4'h5, 1'b1, 1'b0, 18'h0A2CC);
        check("status", {16'h0000, status}, 18'h00001);
        attr(8'h32, 8'h1B);
        check("status", {16'h0000, status}, 18'h00002);
        attr(8'h32, 8'h3B);
        check("status", {16'h0000, status}, 18'h00003);
        attr(8'h30, 8'hC1);
        pix_run(4'h5, 1'b1, 1'b0, 18'h0A2CC);
        check("status", {16'h0000, status}, 18'h00000);
        attr(8'h32, 8'h1B);
        check("status", {16'h0000, status}, 18'h00001);
        attr(8'h30, 8'h01);
        pix.bg_bright = 1'b1;
        pix_run(4'h5, 1'b1, 1'b0, 18'h07209);
        check("status", {16'h0000, status}, 18'h00002);
        attr(8'h30, 8'h09);
        pix.blink_attr = 1'b1;
        // Sixteen frames bring the blink phase to its dark half
        repeat (32)
        begin
            vsync = !vsync;
            repeat (2) @(posedge core_clk_in);
            #1;
        end
        pix_run(4'h5, 1'b1, 1'b0, 18'h07209);
        pix = '{char_code: 8'hC5, ninth_dot: 1'b1, default: '0};
        attr(8'h30, 8'h05);
        pix_run(4'h5, 1'b1, 1'b0, 18'h0A2CC);
        attr(8'h30, 8'h01);
        pix_run(4'h5, 1'b1, 1'b0, 18'h07209);
        io_rd(`APAL_PORT_STAT_COLOR, tmp);
        io_wr(`APAL_PORT_ATTR_WR, 8'h01);
        nrst_in = 1'b0;
        repeat (2) @(posedge core_clk_in);
        #1 nrst_in = 1'b1;
        io_wr(`APAL_PORT_ATTR_WR, 8'h02);
        rd_chk("index", `APAL_PORT_ATTR_WR, 8'h02);
        tally_and_finish();
    end
endmodule // testbench
